// ===== bench/test_cpu_status_flags.sv
`timescale 1ns/10ps
`default_nettype none

module test_cpu_status_flags;

   typedef struct {
      string       nm;
      logic [32:0] exp;
      logic [32:0] msk;
   } csf_note_t;

   localparam logic [32:0] ALL = 33'h1_ffff_ffff;
   localparam logic [32:0] ROT = 33'h1_ffff_fff9;

   logic                core_clk = 1'b0;
   logic                rst = 1'b1;
   logic                instrValid = 1'b0;
   csf_pkg::csf_instr_t instr = '0;
   logic                watchdogExpire = 1'b0;
   logic                ramWrite = 1'b0;
   logic [2:0]          ramBank = 3'h0;
   logic [6:0]          ramAddr = 7'h00;
   logic [7:0]          ramWdata = 8'h00;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [7:0]          paddr = 8'h00;
   logic [31:0]         pwdata = 32'h0;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [7:0]          flags;
   logic [7:0]          result;
   logic [7:0]          ramRdata;
   logic                irq;
   logic                peek = 1'b0;
   logic [1:0]          peekKind = 2'h0;
   logic                timeoutF = 1'b1;
   logic                powerF = 1'b1;
   logic                zeroF = 1'b0;
   logic                halfF = 1'b0;
   logic                carryF = 1'b0;
   logic [7:0]          lastRes = 8'h00;
   logic [7:0]          d [3];
   csf_note_t           notes [$];
   int                  mismatches = 0;
   int                  compares = 0;
   int                  i;

   always #4 core_clk = ~core_clk;

   cpu_status_flags uut (
      .core_clk(core_clk), .rst(rst), .instrValid(instrValid),
      .instr(instr), .watchdogExpire(watchdogExpire),
      .ramWrite(ramWrite), .ramBank(ramBank), .ramAddr(ramAddr),
      .ramWdata(ramWdata), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flags(flags), .result(result), .ramRdata(ramRdata), .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (notes.size() != 0)
         mismatches++;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   function automatic logic [32:0] fexp();
      return {28'h0, timeoutF, powerF, zeroF, halfF, carryF};
   endfunction : fexp

   task automatic note(input string nm, input logic [32:0] e,
                       input logic [32:0] m);
      csf_note_t n;
      n = '{nm, e, m};
      notes.push_back(n);
   endtask : note

   task automatic take(input logic [32:0] v);
      csf_note_t n;
      if (notes.size() == 0)
      begin
         mismatches++;
         $display("CHECK FAILED extra expected none seen %h", v);
      end
      else
      begin
         n = notes.pop_front();
         compares++;
         if ((v & n.msk) !== (n.exp & n.msk))
         begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n.nm,
                     n.exp & n.msk, v & n.msk);
         end
      end
   endtask : take

   // The watcher compares the oldest note with each result that appears.
   always @(posedge core_clk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         take({pslverr, prdata});
      else if (peek)
         take(peekKind == 2'h0 ? {25'h0, flags} :
              peekKind == 2'h1 ? {32'h0, irq} :
              peekKind == 2'h2 ? {25'h0, ramRdata} : {25'h0, result});
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge core_clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++)
      begin
         @(posedge core_clk);
         if (pready === 1'b1)
            break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 16)
      begin
         mismatches++;
         $display("CHECK FAILED pready expected 1 seen 0");
         close_out();
      end
   endtask : apb

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [32:0] e, input logic [32:0] m);
      note(nm, e, m);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic chkp(input logic [1:0] k, input string nm,
                       input logic [7:0] e);
      @(posedge core_clk);
      peek <= 1'b1;
      peekKind <= k;
      note(nm, {25'h0, e}, ALL);
      @(posedge core_clk);
      peek <= 1'b0;
   endtask : chkp

   task automatic ex(input csf_pkg::csf_op_t op, input logic [7:0] a,
                     input logic [7:0] b, input logic dst);
      logic       sb;
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] h;
      @(posedge core_clk);
      instrValid <= 1'b1;
      instr <= '{op, a, b, dst};
      @(posedge core_clk);
      instrValid <= 1'b0;
      sb = (op == csf_pkg::OP_SUB);
      bb = sb ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, sb};
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sb};
      case (op)
         csf_pkg::OP_ADD, csf_pkg::OP_SUB:
         begin
            lastRes = s[7:0];
            zeroF = (s[7:0] == 8'h00);
            halfF = h[4];
            carryF = s[8];
         end
         csf_pkg::OP_ROR:
         begin
            lastRes = {carryF, a[7:1]};
            carryF = a[0];
         end
         csf_pkg::OP_ROL:
         begin
            lastRes = {a[6:0], carryF};
            carryF = a[7];
         end
         csf_pkg::OP_LOGIC, csf_pkg::OP_CLR:
         begin
            lastRes = (op == csf_pkg::OP_CLR) ? 8'h00 : a;
            zeroF = (lastRes == 8'h00);
         end
         csf_pkg::OP_NOFLAG:
         begin
            lastRes = a;
            if (dst)
               {zeroF, halfF, carryF} = a[2:0];
         end
         csf_pkg::OP_WATCHDOG_CLEAR_INSTR:
         begin
            timeoutF = 1'b1;
            powerF = 1'b1;
         end
         csf_pkg::OP_SLEEP:
         begin
            timeoutF = 1'b1;
            powerF = 1'b0;
         end
         default:
            lastRes = lastRes;
      endcase
   endtask : ex

   task automatic arith(input csf_pkg::csf_op_t op, input logic [7:0] a,
                        input logic [7:0] b, input logic dst,
                        input logic [32:0] m);
      ex(op, a, b, dst);
      rd("flags", csf_pkg::ADDR_FLAGS, fexp(), m);
      rd("result", csf_pkg::ADDR_LAST_RES, {25'h0, lastRes}, ALL);
   endtask : arith

   task automatic wdog();
      @(posedge core_clk);
      watchdogExpire <= 1'b1;
      @(posedge core_clk);
      watchdogExpire <= 1'b0;
      timeoutF = 1'b0;
   endtask : wdog

   task automatic ramWr(input logic [2:0] b, input logic [6:0] a,
                        input logic [7:0] v);
      @(posedge core_clk);
      ramWrite <= 1'b1;
      ramBank <= b;
      ramAddr <= a;
      ramWdata <= v;
      @(posedge core_clk);
      ramWrite <= 1'b0;
   endtask : ramWr

   task automatic ramRd(input logic [2:0] b, input logic [6:0] a,
                        input logic [7:0] e);
      @(posedge core_clk);
      ramBank <= b;
      ramAddr <= a;
      chkp(2'h2, "ram", e);
   endtask : ramRd

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(79728));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd("flags reset", csf_pkg::ADDR_FLAGS, 33'h18, ALL);
      rd("mask reset", csf_pkg::ADDR_IRQ_MASK, 33'h0, ALL);
      rd("unmapped", 8'h20, 33'h1_0000_0000, ALL);
      apb(1'b1, csf_pkg::ADDR_FLAGS, 32'h0000_00ff);
      rd("flags ro", csf_pkg::ADDR_FLAGS, fexp(), ALL);
      arith(csf_pkg::OP_ADD, 8'h01, 8'h01, 1'b1, ALL);
      arith(csf_pkg::OP_ADD, 8'h8f, 8'h81, 1'b0, ALL);
      arith(csf_pkg::OP_CLR, 8'h00, 8'h00, 1'b1, ALL);
      arith(csf_pkg::OP_SUB, 8'h10, 8'h20, 1'b0, ALL);
      arith(csf_pkg::OP_SUB, 8'h10, 8'h01, 1'b0, ALL);
      arith(csf_pkg::OP_SUB, 8'h5a, 8'h00, 1'b0, ALL);
      arith(csf_pkg::OP_SUB, 8'h33, 8'h33, 1'b0, ALL);
      for (i = 0; i < 24; i++)
         arith(csf_pkg::csf_op_t'($urandom_range(2, 1)), 8'($urandom),
               8'($urandom), 1'($urandom), ALL);
      for (i = 0; i < 12; i++)
         arith(csf_pkg::csf_op_t'($urandom_range(5, 4)), 8'($urandom),
               8'h00, 1'b0, ROT);
      arith(csf_pkg::OP_ADD, 8'h11, 8'h22, 1'b0, ALL);
      arith(csf_pkg::OP_LOGIC, 8'h00, 8'h00, 1'b0, ALL);
      arith(csf_pkg::OP_LOGIC, 8'h40, 8'h00, 1'b1, ALL);
      ex(csf_pkg::OP_NOFLAG, 8'h00, 8'h00, 1'b0);
      rd("flags kept", csf_pkg::ADDR_FLAGS, fexp(), ALL);
      arith(csf_pkg::OP_NOFLAG, 8'hff, 8'h00, 1'b1, ALL);
      arith(csf_pkg::OP_ROR, 8'h02, 8'h00, 1'b1, ALL);
      chkp(2'h3, "result port", lastRes);
      wdog();
      rd("flags wdog", csf_pkg::ADDR_FLAGS, fexp(), ALL);
      ex(csf_pkg::OP_WATCHDOG_CLEAR_INSTR, 8'h00, 8'h00, 1'b0);
      rd("flags watchdog_clear_instr", csf_pkg::ADDR_FLAGS, fexp(), ALL);
      wdog();
      ex(csf_pkg::OP_SLEEP, 8'h00, 8'h00, 1'b0);
      rd("flags sleep", csf_pkg::ADDR_FLAGS, fexp(), ALL);
      chkp(2'h0, "flags port", 8'(fexp()));
      // A second reset must bring both event flags back to one.
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      {timeoutF, powerF, zeroF, halfF, carryF} = 5'h18;
      rd("flags rst", csf_pkg::ADDR_FLAGS, 33'h18, ALL);
      apb(1'b1, csf_pkg::ADDR_IRQ_STATUS, 32'h7);
      rd("irq clr", csf_pkg::ADDR_IRQ_STATUS, 33'h0, ALL);
      wdog();
      rd("irq wdog", csf_pkg::ADDR_IRQ_STATUS, 33'h1, ALL);
      ex(csf_pkg::OP_SLEEP, 8'h00, 8'h00, 1'b0);
      arith(csf_pkg::OP_ADD, 8'h80, 8'h80, 1'b0, ALL);
      rd("irq all", csf_pkg::ADDR_IRQ_STATUS, 33'h7, ALL);
      chkp(2'h1, "irq masked", 8'h00);
      apb(1'b1, csf_pkg::ADDR_IRQ_MASK, 32'h2);
      chkp(2'h1, "irq on", 8'h01);
      apb(1'b1, csf_pkg::ADDR_IRQ_STATUS, 32'h2);
      chkp(2'h1, "irq off", 8'h00);
      rd("irq w1c", csf_pkg::ADDR_IRQ_STATUS, 33'h5, ALL);
      ramWr(3'h0, 7'h55, 8'ha5);
      ramRd(3'h2, 7'h55, 8'ha5);
      ramWr(3'h1, 7'h0a, 8'h11);
      ramWr(3'h2, 7'h0a, 8'h22);
      ramRd(3'h1, 7'h0a, 8'h11);
      ramWr(3'h3, 7'h4f, 8'h3c);
      ramRd(3'h3, 7'h4f, 8'h3c);
      apb(1'b1, csf_pkg::ADDR_RAM_PTR, 32'h4e);
      for (i = 0; i < 3; i++)
      begin
         d[i] = 8'($urandom);
         apb(1'b1, csf_pkg::ADDR_RAM_DATA, {24'h0, d[i]});
      end
      ramRd(3'h0, 7'h4e, d[0]);
      ramRd(3'h0, 7'h4f, d[1]);
      ramRd(3'h1, 7'h00, d[2]);
      apb(1'b1, csf_pkg::ADDR_RAM_PTR, 32'h4f);
      rd("ram linear", csf_pkg::ADDR_RAM_DATA, {25'h0, d[1]}, ALL);
      repeat (2) @(posedge core_clk);
      close_out();
   end

endmodule : test_cpu_status_flags

`default_nettype wire

// ===== design/cpu_status_flags.sv
// How it works
// - Flag bits 7 to 5 read zero and hold nothing.
// - Timeout flag sets on power-up, and on watchdog clear and sleep unless the watchdog expires in the same cycle.
// - Timeout flag clears when the watchdog timer expires.
// - Powerdown flag sets on power-up and watchdog clear.
// - Powerdown flag clears on sleep.
// - Zero flag follows whether a flag-affecting result is zero.
// - Half-carry is the carry out of bit 3 for add and subtract.
// - Carry is the carry out of bit 7 for add and subtract.
// - In subtraction carry flags are active-low borrows.
// - Subtraction adds the two's complement of the second operand.
// - Rotates through carry load carry with the bit shifted out.
// - Clearing the flag register zeroes top bits and sets zero flag.
// - Each bank holds up to 80 bytes of general RAM.
// - Sixteen common bytes are seen from every bank.
// - Indirect pointer addresses general RAM linearly across banks.
// - Writes to timeout and powerdown flags are ignored.
// - Flag results override written values for zero, half-carry, carry.
`timescale 1ns/10ps
`default_nettype none

module cpu_status_flags
#(
   parameter int RAM_BANK_BYTES = csf_pkg::RAM_BANK_BYTES,
   parameter int COMMON_BYTES   = csf_pkg::COMMON_BYTES,
   parameter int BANKS          = csf_pkg::BANKS
)
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                instrValid,
   input  wire csf_pkg::csf_instr_t instr,
   input  wire logic                watchdogExpire,
   input  wire logic                ramWrite,
   input  wire logic [2:0]          ramBank,
   input  wire logic [6:0]          ramAddr,
   input  wire logic [7:0]          ramWdata,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic [7:0]               flags,
   output logic [7:0]               result,
   output logic [7:0]               ramRdata,
   output logic                     irq
);

   localparam int RAM_SIZE = RAM_BANK_BYTES * BANKS;
   localparam int PW = $clog2(RAM_SIZE + COMMON_BYTES);

   logic       carryFlag;
   logic       halfFlag;
   logic       zeroFlag;
   logic       timeoutFlag;
   logic       powerdownFlag;
   logic [8:0] sum;
   logic [4:0] lowSum;
   logic [7:0] bOperand;
   logic [7:0] next_result;
   logic       next_zero;
   logic       affectsZ;
   logic       affectsCarry;
   logic       next_carry;
   logic       next_half;
   logic [2:0] irqStatus;
   logic [2:0] irqMask;
   logic [2:0] irqEvents;
   logic [PW-1:0] ramPtr;
   logic [7:0] mem [RAM_SIZE + COMMON_BYTES];
   logic       apbWr;
   logic       apbRd;
   logic [7:0] flagView;
   logic       ptrHit;
   logic       flagsWrite;

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic and flag results.

   always_comb
   begin
      // Inverse plus a carry-in of one keeps both borrows exact.
      bOperand = (instr.op == csf_pkg::OP_SUB) ? ~instr.b : instr.b;
      sum = {1'b0, instr.a} + {1'b0, bOperand}
            + {8'h00, instr.op == csf_pkg::OP_SUB};
      lowSum = {1'b0, instr.a[3:0]} + {1'b0, bOperand[3:0]}
               + {4'h0, instr.op == csf_pkg::OP_SUB};
      next_result = 8'h00;
      affectsZ = 1'b0;
      affectsCarry = 1'b0;
      next_carry = carryFlag;
      next_half = halfFlag;
      unique case (instr.op)
         csf_pkg::OP_ADD, csf_pkg::OP_SUB:
         begin
            next_result = sum[7:0];
            affectsZ = 1'b1;
            affectsCarry = 1'b1;
            next_carry = sum[8];
            next_half = lowSum[csf_pkg::NIB];
         end
         csf_pkg::OP_LOGIC:
         begin
            next_result = instr.a;
            affectsZ = 1'b1;
         end
         csf_pkg::OP_ROR:
         begin
            next_result = {carryFlag, instr.a[7:1]};
            next_carry = instr.a[0];
            affectsCarry = 1'b1;
         end
         csf_pkg::OP_ROL:
         begin
            next_result = {instr.a[6:0], carryFlag};
            next_carry = instr.a[7];
            affectsCarry = 1'b1;
         end
         csf_pkg::OP_CLR:
         begin
            next_result = 8'h00;
            affectsZ = 1'b1;
         end
         csf_pkg::OP_NOFLAG: next_result = instr.a;
         csf_pkg::OP_NONE, csf_pkg::OP_WATCHDOG_CLEAR_INSTR, csf_pkg::OP_SLEEP:
            next_result = 8'h00;
         default: next_result = 8'h00;
      endcase
      next_zero = (next_result == 8'h00);
   end

   assign flagsWrite = instrValid && instr.destFlags;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         result <= 8'h00;
      else if (instrValid)
         result <= next_result;
   end

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic flags; flag results win over a write to the register.

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         carryFlag <= 1'b0;
         halfFlag <= 1'b0;
         zeroFlag <= 1'b0;
      end
      else if (instrValid && (affectsZ || affectsCarry))
      begin
         if (affectsZ)
            zeroFlag <= next_zero;
         if (affectsCarry)
            carryFlag <= next_carry;
         if (instr.op == csf_pkg::OP_ADD || instr.op == csf_pkg::OP_SUB)
            halfFlag <= next_half;
      end
      else if (flagsWrite)
      begin
         zeroFlag <= next_result[csf_pkg::BIT_Z];
         halfFlag <= next_result[csf_pkg::BIT_DC];
         carryFlag <= next_result[csf_pkg::BIT_C];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timeout and powerdown flags, changed by events only.

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         timeoutFlag <= 1'b1;
         powerdownFlag <= 1'b1;
      end
      else
      begin
         if (watchdogExpire)
            timeoutFlag <= 1'b0;
         else if (instrValid && (instr.op == csf_pkg::OP_WATCHDOG_CLEAR_INSTR
                              || instr.op == csf_pkg::OP_SLEEP))
            timeoutFlag <= 1'b1;
         if (instrValid && instr.op == csf_pkg::OP_WATCHDOG_CLEAR_INSTR)
            powerdownFlag <= 1'b1;
         else if (instrValid && instr.op == csf_pkg::OP_SLEEP)
            powerdownFlag <= 1'b0;
      end
   end

   assign flagView = {3'b000, timeoutFlag, powerdownFlag,
                      zeroFlag, halfFlag, carryFlag};

   always_ff @(posedge core_clk)
   begin
      if (rst)
         flags <= csf_pkg::FLAGS_RST;
      else
         flags <= flagView;
   end

   ////////////////////////////////////////////////////////////////////////
   // Banked, common and linear data RAM.

   function automatic logic [PW-1:0] bankIndex(input logic [2:0] bank,
                                               input logic [6:0] addr);
      logic [PW-1:0] idx;
      idx = PW'(RAM_SIZE) + PW'(addr) - PW'(RAM_BANK_BYTES);
      if (addr < 7'(RAM_BANK_BYTES))
      begin
         idx = PW'(32'(bank) * RAM_BANK_BYTES + 32'(addr));
      end
      return idx;
   endfunction : bankIndex

   always_ff @(posedge core_clk)
   begin
      if (ramWrite && ramAddr < 7'(RAM_BANK_BYTES + COMMON_BYTES)
          && ramBank < 3'(BANKS))
      begin
         mem[bankIndex(ramBank, ramAddr)] <= ramWdata;
      end
      else if (apbWr && paddr == csf_pkg::ADDR_RAM_DATA
               && ramPtr < PW'(RAM_SIZE))
      begin
         mem[ramPtr] <= pwdata[7:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         ramRdata <= 8'h00;
      else if (ramAddr < 7'(RAM_BANK_BYTES + COMMON_BYTES)
               && ramBank < 3'(BANKS))
         ramRdata <= mem[bankIndex(ramBank, ramAddr)];
      else
         ramRdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave with interrupt status and mask.

   assign apbWr = psel && penable && pwrite && pready;
   assign apbRd = psel && !penable && !pwrite;
   assign ptrHit = apbWr && paddr == csf_pkg::ADDR_RAM_PTR;
   assign irqEvents = {instrValid && affectsZ && next_zero,
                       instrValid && instr.op == csf_pkg::OP_SLEEP,
                       watchdogExpire};

   always_ff @(posedge core_clk)
   begin
      if (rst)
         ramPtr <= '0;
      else if (ptrHit)
         ramPtr <= pwdata[PW-1:0];
      else if (apbWr && paddr == csf_pkg::ADDR_RAM_DATA)
         ramPtr <= PW'(ramPtr + 1'b1);
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         irqStatus <= 3'h0;
         irqMask <= 3'h0;
      end
      else
      begin
         if (apbWr && paddr == csf_pkg::ADDR_IRQ_STATUS)
         begin
            irqStatus <= (irqStatus & ~pwdata[2:0]) | irqEvents;
         end
         else
         begin
            irqStatus <= irqStatus | irqEvents;
         end
         if (apbWr && paddr == csf_pkg::ADDR_IRQ_MASK)
         begin
            irqMask <= pwdata[2:0];
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irqStatus & irqMask);
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr >= csf_pkg::APB_W;
         if (apbRd)
         begin
            unique case (paddr)
               csf_pkg::ADDR_FLAGS:      prdata <= {24'h0, flagView};
               csf_pkg::ADDR_IRQ_STATUS: prdata <= {29'h0, irqStatus};
               csf_pkg::ADDR_IRQ_MASK:   prdata <= {29'h0, irqMask};
               csf_pkg::ADDR_RAM_PTR:    prdata <= 32'(ramPtr);
               csf_pkg::ADDR_RAM_DATA:   prdata <= (ramPtr < PW'(RAM_SIZE))
                                                   ? {24'h0, mem[ramPtr]}
                                                   : 32'h0000_0000;
               csf_pkg::ADDR_LAST_RES:   prdata <= {24'h0, result};
               default:                  prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_upper_zero;
      @(posedge core_clk) disable iff (rst) flags[7:5] == 3'b000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper set");

   property p_to_set;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_WATCHDOG_CLEAR_INSTR && !watchdogExpire
      |=> timeoutFlag ##1 flags[csf_pkg::BIT_TO];
   endproperty
   a_to_set: assert property (p_to_set) else $error("to not set");

   property p_to_clr;
      @(posedge core_clk) disable iff (rst)
      watchdogExpire |=> !timeoutFlag;
   endproperty
   a_to_clr: assert property (p_to_clr) else $error("to not clr");

   property p_pd_set;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_WATCHDOG_CLEAR_INSTR |=> powerdownFlag;
   endproperty
   a_pd_set: assert property (p_pd_set) else $error("pd not set");

   property p_pd_clr;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_SLEEP |=> ##1 !flags[3];
   endproperty
   a_pd_clr: assert property (p_pd_clr) else $error("pd not clr");

   property p_zero;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_ADD
      |=> zeroFlag == (result == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero wrong");

   property p_carry;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_ADD
      |=> carryFlag == (({1'b0, $past(instr.a)} + {1'b0, $past(instr.b)})
                        > 9'h0ff);
   endproperty
   a_carry: assert property (p_carry) else $error("carry wrong");

   property p_rot;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_ROR |=> carryFlag == $past(instr.a[0]);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate carry");

   property p_sub_borrow;
      @(posedge core_clk) disable iff (rst)
      instrValid && instr.op == csf_pkg::OP_SUB
      |=> carryFlag == ($past(instr.a) >= $past(instr.b));
   endproperty
   a_sub_borrow: assert property (p_sub_borrow)
      else $error("borrow wrong");

endmodule : cpu_status_flags

`default_nettype wire

// ===== design/csf_pkg.sv
package csf_pkg;

   localparam int FLAG_W = 8;
   localparam logic [7:0] APB_W = 8'h20;

   // Register byte addresses.
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_RAM_PTR = 8'h0c;
   localparam logic [7:0] ADDR_RAM_DATA = 8'h10;
   localparam logic [7:0] ADDR_LAST_RES = 8'h14;

   // Flag register value after any reset: timeout and powerdown set.
   localparam logic [7:0] FLAGS_RST = 8'h18;

   // Flag bit positions.
   localparam int BIT_C = 0;
   localparam int BIT_DC = 1;
   localparam int BIT_Z = 2;
   localparam int BIT_PD = 3;
   localparam int BIT_TO = 4;

   // Interrupt status bit positions.
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_SLEEP = 1;
   localparam int IRQ_ZERO = 2;
   localparam int IRQ_W = 3;

   localparam int RAM_BANK_BYTES = 80;
   localparam int COMMON_BYTES = 16;
   localparam int BANKS = 4;
   localparam int NIB = 4;

   typedef enum logic [3:0]
   {
      OP_NONE = 4'h0,
      OP_ADD = 4'h1,
      OP_SUB = 4'h2,
      OP_LOGIC = 4'h3,
      OP_ROR = 4'h4,
      OP_ROL = 4'h5,
      OP_CLR = 4'h6,
      OP_NOFLAG = 4'h7,
      OP_WATCHDOG_CLEAR_INSTR = 4'h8,
      OP_SLEEP = 4'h9
   } csf_op_t;

   typedef struct packed
   {
      csf_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
      logic       destFlags;
   } csf_instr_t;

endpackage : csf_pkg
